// ---- rtl/line_ef_pkg.sv ----
/*
 * Constants, register indices and types shared by the output line generator
 * and its count source. Assumes nothing of its surroundings.
 */
package line_ef_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned REG_IDX_W = 4;

    // register indices on the register access port
    localparam logic [3:0] IDX_LINE_FEATURE_ENABLE = 4'h0;
    localparam logic [3:0] IDX_LINE_FEATURE_SELECT = 4'h1;
    localparam logic [3:0] IDX_LINE_FEATURE_OPTIONS = 4'h2;
    localparam logic [3:0] IDX_FALLING_COMPARE_POINT = 4'h3;
    localparam logic [3:0] IDX_RISING_COMPARE_POINT = 4'h4;
    localparam logic [3:0] IDX_PULSE_TARGET_COUNT = 4'h5;
    localparam logic [3:0] IDX_PULSES_COMPLETED = 4'h6;
    localparam logic [3:0] IDX_PULSES_TARGET_READBACK = 4'h7;
    localparam logic [3:0] IDX_PULSES_COMPLETED_RESTART = 4'h8;
    localparam logic [3:0] IDX_TICK_DIVIDER = 4'h9;
    localparam logic [3:0] IDX_COUNT_WRAP_VALUE = 4'ha;

    // source-select field of the options register
    localparam int unsigned SRC_W = 3;
    localparam logic [2:0] SRC_ZERO = 3'h0;
    localparam logic [2:0] SRC_ONE = 3'h1;
    localparam logic [2:0] SRC_TWO = 3'h2;

    // function index held in the select register
    localparam logic [31:0] MODE_PHASED_PWM = 32'h0000_0001;
    localparam logic [31:0] MODE_PULSE_TRAIN = 32'h0000_0002;

    // divider: 256 is the largest legal divisor, zero acts as one
    localparam int unsigned DIV_W = 9;
    localparam logic [8:0] DIV_AS_ONE = 9'h001;
    localparam logic [8:0] DIV_ZERO = 9'h000;

    // core clock that the divider is specified against
    localparam int unsigned CORE_CLOCK_RATE_HZ = 80_000_000;

    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] WORD_ONE = 32'h0000_0001;
    localparam logic [31:0] WRAP_FULL_RANGE = 32'h0000_0000;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RUN,
        SEQ_DONE
    } seq_state_t;

endpackage

// ---- rtl/shared_count_source.sv ----
/*
 * Shared clock-source count: a prescaler that makes the count tick and a
 * 32-bit count that wraps at a programmable value.
 * Assumes a synchronous active-low reset already released cleanly.
 */
module shared_count_source
    import line_ef_pkg::*;
(
    input wire logic clk,
    input wire logic rst_sync_n,
    input wire logic [line_ef_pkg::DIV_W-1:0] tick_divider,
    input wire logic [line_ef_pkg::DATA_W-1:0] count_wrap_value,
    output logic [line_ef_pkg::DATA_W-1:0] count,
    output logic tick
);
    logic [DIV_W-1:0] pre_r;
    logic [DIV_W-1:0] pre_nxt;
    logic [DATA_W-1:0] count_r;
    logic [DATA_W-1:0] count_nxt;
    logic tick_r;
    logic tick_nxt;
    logic [DIV_W-1:0] div_eff;

    always_comb begin
        div_eff = (tick_divider == DIV_ZERO) ? DIV_AS_ONE : tick_divider; // RULE16
        // clk plays the core clock here; its nominal rate is a package constant
        pre_nxt = pre_r + DIV_AS_ONE; // RULE17
        tick_nxt = 1'b0;
        count_nxt = count_r;
        // >= so a smaller divider or wrap taken mid-run cannot overshoot
        if (pre_r >= div_eff - DIV_AS_ONE) begin // RULE16
            pre_nxt = DIV_ZERO;
            tick_nxt = 1'b1;
            if (count_wrap_value != WRAP_FULL_RANGE
                    && count_r >= count_wrap_value - WORD_ONE) begin // RULE19
                count_nxt = WORD_ZERO;
            end else begin
                count_nxt = count_r + WORD_ONE; // RULE19
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pre_r <= DIV_ZERO;
            count_r <= WORD_ZERO;
            tick_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            count_r <= count_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign count = count_r;
    assign tick = tick_r;

endmodule

// ---- rtl/line_extended_function.sv ----
/*
 * One digital output line with phased PWM and pulse-train functions, its
 * configuration and result registers and the shared count source.
 * Assumes register accesses arrive as single-cycle strobes synchronous to clk
 * and that the pin pad resolves the line level from line_oe.
 */
// Summary of operation
// RULE1 - phased PWM: count equals rising point, line high
// RULE2 - phased PWM: count equals falling point, line low
// RULE3 - options bits 2:0 pick count source
// RULE4 - enable register: zero off, one on
// RULE5 - new PWM points load at next period start
// RULE6 - falling write waits for following rising write
// RULE7 - PWM updates glitch-free except extreme duty jumps
// RULE8 - software drives line low before pulse train
// RULE9 - pulse edges from compare points as PWM
// RULE10 - third config register holds pulse count
// RULE11 - pulse-count write aborts and starts new sequence
// RULE12 - pulse mode: points apply on pulse-count write
// RULE13 - first result returns completed pulse count
// RULE14 - second result returns target pulse count
// RULE15 - restart read returns completed then restarts sequence
// RULE16 - tick is core clock over divisor, zero one
// RULE17 - core clock runs at 80 MHz
// RULE18 - pulse period equals one full count wrap
// RULE19 - count wraps at roll value, zero full range
// RULE20 - select one phased PWM, two pulse train
// RULE21 - after last pulse line held low
module line_extended_function
    import line_ef_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [line_ef_pkg::REG_IDX_W-1:0] wr_idx,
    input wire logic [line_ef_pkg::DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [line_ef_pkg::REG_IDX_W-1:0] rd_idx,
    output logic [line_ef_pkg::DATA_W-1:0] rd_data,
    output logic line_out,
    output logic line_oe
);
    import line_ef_pkg::*;

    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // configuration
    logic en_r, en_nxt;
    logic [DATA_W-1:0] mode_r, mode_nxt;
    logic [SRC_W-1:0] src_r, src_nxt;
    logic [DATA_W-1:0] fall_pend_r, fall_pend_nxt;
    logic [DATA_W-1:0] rise_pend_r, rise_pend_nxt;
    logic [DATA_W-1:0] target_r, target_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic [DATA_W-1:0] wrap_r, wrap_nxt;
    // operating state
    logic [DATA_W-1:0] fall_stg_r, fall_stg_nxt;
    logic [DATA_W-1:0] rise_stg_r, rise_stg_nxt;
    logic upd_r, upd_nxt;
    logic [DATA_W-1:0] fall_act_r, fall_act_nxt;
    logic [DATA_W-1:0] rise_act_r, rise_act_nxt;
    logic [DATA_W-1:0] done_r, done_nxt;
    seq_state_t seq_r, seq_nxt;
    logic out_r, out_nxt;
    logic [DATA_W-1:0] rd_data_r, rd_data_nxt;

    logic [DATA_W-1:0] src_count;
    logic src_tick;
    logic [DATA_W-1:0] sel_count;
    logic period_start;
    logic hit_rise;
    logic hit_fall;
    logic wr_hit_en, wr_hit_sel, wr_hit_opt, wr_hit_fall, wr_hit_rise;
    logic wr_hit_tgt, wr_hit_div, wr_hit_wrap;
    logic rd_restart;

    shared_count_source u_count (
        .clk(clk),
        .rst_sync_n(rst_sync_n),
        .tick_divider(div_r),
        .count_wrap_value(wrap_r),
        .count(src_count),
        .tick(src_tick)
    );

    // sources one and two are the low and high halves of source zero
    always_comb begin
        if (src_r == SRC_ONE) begin // RULE3
            sel_count = {{HALF_W{1'b0}}, src_count[HALF_W-1:0]};
        end else if (src_r == SRC_TWO) begin // RULE3
            sel_count = {{HALF_W{1'b0}}, src_count[DATA_W-1:HALF_W]};
        end else begin
            sel_count = src_count; // RULE3
        end
    end

    assign period_start = src_tick && (sel_count == WORD_ZERO);

    always_comb begin
        wr_hit_en = wr_en && (wr_idx == IDX_LINE_FEATURE_ENABLE);
        wr_hit_sel = wr_en && (wr_idx == IDX_LINE_FEATURE_SELECT);
        wr_hit_opt = wr_en && (wr_idx == IDX_LINE_FEATURE_OPTIONS);
        wr_hit_fall = wr_en && (wr_idx == IDX_FALLING_COMPARE_POINT);
        wr_hit_rise = wr_en && (wr_idx == IDX_RISING_COMPARE_POINT);
        wr_hit_tgt = wr_en && (wr_idx == IDX_PULSE_TARGET_COUNT);
        wr_hit_div = wr_en && (wr_idx == IDX_TICK_DIVIDER);
        wr_hit_wrap = wr_en && (wr_idx == IDX_COUNT_WRAP_VALUE);
        rd_restart = rd_en && (rd_idx == IDX_PULSES_COMPLETED_RESTART);
    end

    always_comb begin
        en_nxt = en_r;
        mode_nxt = mode_r;
        src_nxt = src_r;
        fall_pend_nxt = fall_pend_r;
        rise_pend_nxt = rise_pend_r;
        target_nxt = target_r;
        div_nxt = div_r;
        wrap_nxt = wrap_r;
        fall_stg_nxt = fall_stg_r;
        rise_stg_nxt = rise_stg_r;
        upd_nxt = upd_r;
        fall_act_nxt = fall_act_r;
        rise_act_nxt = rise_act_r;
        done_nxt = done_r;
        seq_nxt = seq_r;
        out_nxt = out_r;
        hit_rise = 1'b0;
        hit_fall = 1'b0;

        // waveform, evaluated once per count value
        if (en_r && src_tick) begin
            if (mode_r == MODE_PHASED_PWM) begin // RULE20
                // staged pair loads only on a period boundary
                if (upd_r && period_start) begin // RULE5 RULE7
                    fall_act_nxt = fall_stg_r;
                    rise_act_nxt = rise_stg_r;
                    upd_nxt = 1'b0;
                end
                hit_rise = (sel_count == rise_act_nxt);
                hit_fall = (sel_count == fall_act_nxt);
                if (hit_rise) begin
                    out_nxt = 1'b1; // RULE1
                end
                // equal points: low wins, line stays quiet
                if (hit_fall) begin
                    out_nxt = 1'b0; // RULE2
                end
            end else if (mode_r == MODE_PULSE_TRAIN && seq_r == SEQ_RUN) begin // RULE20
                hit_rise = (sel_count == rise_act_r);
                hit_fall = (sel_count == fall_act_r);
                if (hit_rise) begin
                    out_nxt = 1'b1; // RULE9 RULE18
                end
                if (hit_fall) begin
                    out_nxt = 1'b0; // RULE9
                    if (out_r) begin
                        done_nxt = done_r + WORD_ONE; // RULE13
                        if (done_r + WORD_ONE >= target_r) begin
                            seq_nxt = SEQ_DONE; // RULE21
                        end
                    end
                end
            end
        end

        if (rd_restart) begin
            done_nxt = WORD_ZERO; // RULE15
            seq_nxt = (target_r == WORD_ZERO) ? SEQ_DONE : SEQ_RUN; // RULE15
            out_nxt = 1'b0;
        end

        if (wr_hit_en) begin
            en_nxt = wr_data[0]; // RULE4
            if (!wr_data[0]) begin
                seq_nxt = SEQ_IDLE;
                out_nxt = 1'b0; // RULE4
            end
        end
        // function changes are refused while the line runs
        if (wr_hit_sel && !en_r) begin
            mode_nxt = wr_data; // RULE20
        end
        if (wr_hit_opt) begin
            src_nxt = wr_data[SRC_W-1:0]; // RULE3
        end
        if (wr_hit_fall) begin
            fall_pend_nxt = wr_data; // RULE6
        end
        if (wr_hit_rise) begin
            rise_pend_nxt = wr_data;
            if (mode_r == MODE_PHASED_PWM) begin // RULE12
                // capture the pair so a later falling write cannot leak in
                fall_stg_nxt = wr_hit_fall ? wr_data : fall_pend_r; // RULE6
                rise_stg_nxt = wr_data;
                upd_nxt = 1'b1; // RULE5
            end
        end
        if (wr_hit_tgt) begin
            target_nxt = wr_data; // RULE10
            fall_act_nxt = fall_pend_r; // RULE12
            rise_act_nxt = rise_pend_r; // RULE12
            done_nxt = WORD_ZERO; // RULE11
            seq_nxt = (wr_data == WORD_ZERO) ? SEQ_DONE : SEQ_RUN; // RULE11
            out_nxt = 1'b0; // RULE11
        end
        if (wr_hit_div) begin
            div_nxt = wr_data[DIV_W-1:0]; // RULE16
        end
        if (wr_hit_wrap) begin
            wrap_nxt = wr_data; // RULE19
        end
    end

    // read data, one cycle after the strobe
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (rd_en) begin
            if (rd_idx == IDX_LINE_FEATURE_ENABLE) begin
                rd_data_nxt = {{(DATA_W-1){1'b0}}, en_r};
            end else if (rd_idx == IDX_LINE_FEATURE_SELECT) begin
                rd_data_nxt = mode_r;
            end else if (rd_idx == IDX_LINE_FEATURE_OPTIONS) begin
                rd_data_nxt = {{(DATA_W-SRC_W){1'b0}}, src_r};
            end else if (rd_idx == IDX_FALLING_COMPARE_POINT) begin
                rd_data_nxt = fall_pend_r;
            end else if (rd_idx == IDX_RISING_COMPARE_POINT) begin
                rd_data_nxt = rise_pend_r;
            end else if (rd_idx == IDX_PULSE_TARGET_COUNT) begin
                rd_data_nxt = target_r;
            end else if (rd_idx == IDX_PULSES_COMPLETED) begin
                rd_data_nxt = done_r; // RULE13
            end else if (rd_idx == IDX_PULSES_TARGET_READBACK) begin
                rd_data_nxt = target_r; // RULE14
            end else if (rd_idx == IDX_PULSES_COMPLETED_RESTART) begin
                rd_data_nxt = done_r; // RULE15
            end else if (rd_idx == IDX_TICK_DIVIDER) begin
                rd_data_nxt = {{(DATA_W-DIV_W){1'b0}}, div_r};
            end else if (rd_idx == IDX_COUNT_WRAP_VALUE) begin
                rd_data_nxt = wrap_r;
            end else begin
                rd_data_nxt = WORD_ZERO;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            en_r <= 1'b0;
            mode_r <= MODE_PHASED_PWM;
            src_r <= SRC_ZERO;
            fall_pend_r <= WORD_ZERO;
            rise_pend_r <= WORD_ZERO;
            target_r <= WORD_ZERO;
            div_r <= DIV_ZERO;
            wrap_r <= WRAP_FULL_RANGE;
            fall_stg_r <= WORD_ZERO;
            rise_stg_r <= WORD_ZERO;
            upd_r <= 1'b0;
            fall_act_r <= WORD_ZERO;
            rise_act_r <= WORD_ZERO;
            done_r <= WORD_ZERO;
            seq_r <= SEQ_IDLE;
            out_r <= 1'b0;
            rd_data_r <= WORD_ZERO;
        end else begin
            en_r <= en_nxt;
            mode_r <= mode_nxt;
            src_r <= src_nxt;
            fall_pend_r <= fall_pend_nxt;
            rise_pend_r <= rise_pend_nxt;
            target_r <= target_nxt;
            div_r <= div_nxt;
            wrap_r <= wrap_nxt;
            fall_stg_r <= fall_stg_nxt;
            rise_stg_r <= rise_stg_nxt;
            upd_r <= upd_nxt;
            fall_act_r <= fall_act_nxt;
            rise_act_r <= rise_act_nxt;
            done_r <= done_nxt;
            seq_r <= seq_nxt;
            out_r <= out_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;
    assign line_out = out_r;
    // line is released while the generator is off
    assign line_oe = en_r;

endmodule

// ---- test/line_load.sv ----
/* Load model on the output line: pin level and a tally of rising edges.
   Assumes a pull-down on the pin, so an undriven line reads low. */
module line_load (
    input wire logic clk,
    input wire logic clr,
    input wire logic line_out,
    input wire logic line_oe,
    output logic pin,
    output logic [15:0] rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_r;
    // pull-down: the line starts low before any pulse train
    assign pin = line_oe ? line_out : 1'b0;
    always @(posedge clk) begin
        last_r <= pin;
        rises <= clr ? 16'h0 : rises + {15'h0, pin & ~last_r};
    end
endmodule

// ---- test/line_ef_asserts.sv ----
/* Port checker for the output line generator.
   Assumes it is bound to line_extended_function. */
module line_ef_asserts
    import line_ef_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [line_ef_pkg::REG_IDX_W-1:0] wr_idx,
    input wire logic [line_ef_pkg::DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [line_ef_pkg::REG_IDX_W-1:0] rd_idx,
    input wire logic [line_ef_pkg::DATA_W-1:0] rd_data,
    input wire logic line_out,
    input wire logic line_oe
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic en_wr;
    logic rs_rd;
    assign en_wr = wr_en && wr_idx == IDX_LINE_FEATURE_ENABLE;
    assign rs_rd = rd_en && rd_idx == IDX_PULSES_COMPLETED_RESTART && !wr_en;
    a_oe_turn_on: assert property (
        en_wr && wr_data == WORD_ONE |-> ##[1:2] line_oe) else $error("oe stuck low");
    a_oe_turn_off: assert property (
        en_wr && wr_data == WORD_ZERO |-> ##[1:2] !line_oe) else $error("oe stuck high");
    a_oe_needs_write: assert property (
        $changed(line_oe) |-> $past(en_wr) || $past(en_wr, 2))
        else $error("oe moved without enable write");
    a_off_line_low: assert property (
        !line_oe && !$past(line_oe) |-> !line_out) else $error("line high while off");
    a_target_readback: assert property (
        wr_en && wr_idx == IDX_PULSE_TARGET_COUNT ##2
        rd_en && rd_idx == IDX_PULSES_TARGET_READBACK |=> rd_data == $past(wr_data, 3))
        else $error("target readback wrong");
    a_restart_clears: assert property (
        rs_rd ##1 rd_en && rd_idx == IDX_PULSES_COMPLETED |=> rd_data == WORD_ZERO)
        else $error("completed not cleared");
    a_restart_low: assert property (
        rs_rd |=> !line_out) else $error("line high after restart");
    a_start_low: assert property (
        wr_en && wr_idx == IDX_PULSE_TARGET_COUNT |=> !line_out)
        else $error("line high after new sequence");
    c_restart: cover property (rs_rd);
    c_pulse: cover property ($rose(line_out));
    c_disable: cover property ($fell(line_oe));
endmodule
bind line_extended_function line_ef_asserts chk_u (
    .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .rd_en(rd_en), .rd_idx(rd_idx), .rd_data(rd_data), .line_out(line_out),
    .line_oe(line_oe)
);

// ---- test/tb_top.sv ----
/* Self-checking bench for the output line generator.
   Assumes the design, its checker and the line_load model are compiled. */
module tb_top
    import line_ef_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic clr = 1'b1;
    logic [3:0] wr_idx = 4'h0;
    logic [3:0] rd_idx = 4'h0;
    logic [31:0] wr_data = 32'h0;
    logic [31:0] rd_data;
    logic [15:0] rises;
    logic line_out;
    logic line_oe;
    logic pin;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] hi;
    logic [31:0] ri;
    always #4 clk = ~clk;
    line_extended_function dut_u (.clk(clk), .rst_n(rst_n), .wr_en(wr_en),
        .wr_idx(wr_idx), .wr_data(wr_data), .rd_en(rd_en), .rd_idx(rd_idx),
        .rd_data(rd_data), .line_out(line_out), .line_oe(line_oe));
    line_load load_u (.clk(clk), .clr(clr), .line_out(line_out), .line_oe(line_oe),
        .pin(pin), .rises(rises));
    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] i, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_idx <= i;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] i, input logic [31:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_idx <= i;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
    endtask
    // 64 cycles span whole periods, so counts do not depend on phase
    task automatic meas();
        logic p;
        hi = 32'h0;
        ri = 32'h0;
        #1 p = pin;
        repeat (64) begin
            @(posedge clk);
            // logic sums keep an unknown pin visible to the compare
            #1 hi += 32'(pin);
            ri += 32'(pin & ~p);
            p = pin;
        end
    endtask
    task automatic pwm(input int h, input int n);
        repeat (24) @(posedge clk);
        meas();
        chk(hi, h);
        chk(ri, n);
    endtask
    task automatic pulse(input int n, input int h);
        wr(IDX_PULSE_TARGET_COUNT, 32'(n));
        meas();
        chk(hi, h);
        chk(ri, n);
        rd(IDX_PULSES_COMPLETED, 32'(n));
        rd(IDX_PULSES_TARGET_READBACK, 32'(n));
        chk({31'h0, pin}, WORD_ZERO);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            if (k != 8 && (k < 11 || k == 15)) begin
                rd(4'(k), (k == 1) ? MODE_PHASED_PWM : WORD_ZERO);
            end
        end
        $display("test reset values done");
        wr(IDX_COUNT_WRAP_VALUE, 32'h8);
        wr(IDX_FALLING_COMPARE_POINT, 32'h5);
        wr(IDX_RISING_COMPARE_POINT, 32'h2);
        wr(IDX_LINE_FEATURE_ENABLE, WORD_ONE);
        pwm(24, 8);
        wr(IDX_FALLING_COMPARE_POINT, 32'h7);
        pwm(24, 8);
        wr(IDX_RISING_COMPARE_POINT, 32'h1);
        pwm(48, 8);
        for (int d = 1; d <= 4; d *= 2) begin
            wr(IDX_TICK_DIVIDER, 32'(d));
            pwm(48, 8 / d);
        end
        wr(IDX_TICK_DIVIDER, WORD_ZERO);
        wr(IDX_LINE_FEATURE_OPTIONS, 32'h1);
        pwm(48, 8);
        wr(IDX_LINE_FEATURE_OPTIONS, 32'h2);
        repeat (24) @(posedge clk);
        meas();
        chk(ri, 0);
        wr(IDX_LINE_FEATURE_OPTIONS, WORD_ZERO);
        $display("test phased pwm done");
        wr(IDX_LINE_FEATURE_SELECT, MODE_PULSE_TRAIN);
        rd(IDX_LINE_FEATURE_SELECT, MODE_PHASED_PWM);
        wr(IDX_LINE_FEATURE_ENABLE, WORD_ZERO);
        repeat (2) @(posedge clk);
        #1 chk({30'h0, line_oe, line_out}, WORD_ZERO);
        wr(IDX_LINE_FEATURE_SELECT, MODE_PULSE_TRAIN);
        wr(IDX_FALLING_COMPARE_POINT, 32'h5);
        wr(IDX_RISING_COMPARE_POINT, 32'h2);
        #1 chk({31'h0, pin}, WORD_ZERO);
        wr(IDX_LINE_FEATURE_ENABLE, WORD_ONE);
        clr <= 1'b0;
        pulse(3, 9);
        chk({16'h0, rises}, 32'h3);
        wr(IDX_FALLING_COMPARE_POINT, 32'h7);
        rd(IDX_PULSES_COMPLETED, 32'h3);
        pulse(1, 5);
        $display("test pulse train done");
        @(posedge clk);
        rd_en <= 1'b1;
        rd_idx <= IDX_PULSES_COMPLETED_RESTART;
        @(posedge clk);
        rd_idx <= IDX_PULSES_COMPLETED;
        #1 chk(rd_data, WORD_ONE);
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, WORD_ZERO);
        meas();
        // the restarted pulse may rise before meas samples, so use the tally
        chk({16'h0, rises}, 32'h5);
        rd(IDX_PULSES_COMPLETED, WORD_ONE);
        wr(IDX_PULSE_TARGET_COUNT, 32'h4);
        rd(IDX_PULSES_TARGET_READBACK, 32'h4);
        repeat (8) @(posedge clk);
        pulse(2, 10);
        $display("test restart and abort done");
        wr(IDX_LINE_FEATURE_ENABLE, WORD_ZERO);
        wr(IDX_LINE_FEATURE_SELECT, 32'h3);
        wr(IDX_LINE_FEATURE_ENABLE, WORD_ONE);
        meas();
        chk(hi, 32'h0);
        rd(IDX_LINE_FEATURE_SELECT, 32'h3);
        $display("test unknown mode done");
        summarize();
    end
endmodule
